// File: core/pia_regs.svh
`ifndef PIA_REGS_SVH
`define PIA_REGS_SVH

// register indices; byte address is four times the index
`define PIA_IDX_SUMMARY   16'h4010
`define PIA_IDX_STATUS    16'h4011
`define PIA_IDX_MASK      16'h4020
`define PIA_IDX_TRIG      16'h4021

// summary bit positions
`define PIA_SUM_POWER     15
`define PIA_SUM_THERMAL   14
`define PIA_SUM_GPIO      13
`define PIA_SUM_ONKEY     12
`define PIA_SUM_WDOG      11
`define PIA_SUM_CONV      8
`define PIA_SUM_PPATH     7
`define PIA_SUM_CLOCK     5
`define PIA_SUM_OTP       4
`define PIA_SUM_CURRENT   1
`define PIA_SUM_UNDERV    0
`define PIA_SUM_USED      16'hf9b3

// status bit positions
`define PIA_ST_LOWSUP     15
`define PIA_ST_ONKEY      12
`define PIA_ST_WDOG       11
`define PIA_ST_CONV       8
`define PIA_ST_CMP_LO     4
`define PIA_ST_TICK       3
`define PIA_ST_ALARM      2
`define PIA_ST_THERM      1
`define PIA_ST_USED       16'h99fe

// reset values
`define PIA_RST_SUMMARY   16'h0000
`define PIA_RST_STATUS    16'h0000
`define PIA_RST_MASK      16'h0000
`define PIA_RST_TRIG      4'hf

// bus responses
`define PIA_RESP_OKAY     2'h0
`define PIA_RESP_DECERR   2'h3

`endif

// File: core/pia_pkg.sv
package pia_pkg;
  typedef logic [15:0] pia_word_t;

  typedef struct packed {
    logic       low_supply_threshold;
    logic       onkey_pin;
    logic       watchdog_timeout;
    logic       converter_result_ready;
    logic [3:0] comparator_hit;
    logic       periodic_tick;
    logic       alarm_match;
    logic       thermal_warning;
  } pia_src_s;

  typedef enum {
    PIA_SEL_SUMMARY,
    PIA_SEL_STATUS,
    PIA_SEL_MASK,
    PIA_SEL_TRIG,
    PIA_SEL_NONE
  } pia_sel_e;
endpackage

// File: core/pia_edge_sync.sv
`timescale 1ns/10ps
// two-stage synchroniser followed by a previous-level stage
module pia_edge_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // meta_q is read only by sync_q
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign level[i] = sync_q[i];
      assign rise[i]  = sync_q[i] & ~prev_q[i];
      assign fall[i]  = ~sync_q[i] & prev_q[i];
    end
  endgenerate
endmodule

// File: core/pia_top.sv
`timescale 1ns/10ps
`include "pia_regs.svh"
module pia_top (
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire pia_pkg::pia_src_s event_src,
  input  wire pia_pkg::pia_word_t group_pending_in,
  output logic                   irq
);
  import pia_pkg::*;

  function automatic pia_sel_e decode(input logic [31:0] addr);
    pia_sel_e sel;
    sel = PIA_SEL_NONE;
    if (addr[31:18] != 14'h0000 || addr[1:0] != 2'h0) begin
      sel = PIA_SEL_NONE;
    end else if (addr[17:2] == `PIA_IDX_SUMMARY) begin
      sel = PIA_SEL_SUMMARY;
    end else if (addr[17:2] == `PIA_IDX_STATUS) begin
      sel = PIA_SEL_STATUS;
    end else if (addr[17:2] == `PIA_IDX_MASK) begin
      sel = PIA_SEL_MASK;
    end else if (addr[17:2] == `PIA_IDX_TRIG) begin
      sel = PIA_SEL_TRIG;
    end
    return sel;
  endfunction

  // ---------------- source sampling ----------------
  // only edges set status bits; the level taps stay open
  pia_src_s  src_rise;
  pia_src_s  src_fall;
  pia_word_t grp_level;

  pia_edge_sync #(
    .W($bits(pia_src_s))
  ) u_src_sync (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .async_in (event_src),
    .level    (),
    .rise     (src_rise),
    .fall     (src_fall)
  );

  // groups whose secondary registers live elsewhere arrive as levels
  pia_edge_sync #(
    .W(16)
  ) u_grp_sync (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .async_in (group_pending_in),
    .level    (grp_level),
    .rise     (),
    .fall     ()
  );

  // ---------------- write channel ----------------
  logic        aw_have_q;
  logic        aw_have_d;
  logic [31:0] aw_addr_q;
  logic [31:0] aw_addr_d;
  logic        w_have_q;
  logic        w_have_d;
  logic [31:0] w_data_q;
  logic [31:0] w_data_d;
  logic [3:0]  w_strb_q;
  logic [3:0]  w_strb_d;
  logic        awready_q;
  logic        awready_d;
  logic        wready_q;
  logic        wready_d;
  logic        bvalid_q;
  logic        bvalid_d;
  logic [1:0]  bresp_q;
  logic [1:0]  bresp_d;
  logic        wr_fire;
  pia_sel_e    wr_sel;
  pia_word_t   wr_bits;

  assign wr_sel  = decode(aw_addr_q);
  // only the low two lanes carry register bits
  assign wr_bits = w_data_q[15:0] & {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d  = w_have_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    wr_fire   = 1'b0;
    if (s_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_have_q && w_have_q && !bvalid_q) begin
      wr_fire   = 1'b1;
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      // summary writes are accepted and dropped
      bresp_d   = (wr_sel == PIA_SEL_NONE) ? `PIA_RESP_DECERR : `PIA_RESP_OKAY;
    end
    awready_d = !aw_have_d;
    wready_d  = !w_have_d;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 32'h0000_0000;
      w_have_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `PIA_RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q  <= w_have_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  // ---------------- event registers ----------------
  pia_word_t status_q;
  pia_word_t status_d;
  pia_word_t mask_q;
  pia_word_t mask_d;
  logic [3:0] trig_q;
  logic [3:0] trig_d;
  pia_word_t summary_q;
  pia_word_t summary_d;
  logic      irq_q;
  logic      irq_d;
  pia_word_t set_vec;
  pia_word_t clr_vec;
  pia_word_t live;

  always_comb begin
    set_vec = 16'h0000;
    set_vec[`PIA_ST_LOWSUP] = src_rise.low_supply_threshold;
    set_vec[`PIA_ST_TICK]   = src_rise.periodic_tick;
    set_vec[`PIA_ST_ALARM]  = src_rise.alarm_match;
    set_vec[`PIA_ST_ONKEY]  = src_rise.onkey_pin | src_fall.onkey_pin;
    set_vec[`PIA_ST_THERM]  = src_rise.thermal_warning | src_fall.thermal_warning;
    set_vec[`PIA_ST_WDOG]   = src_rise.watchdog_timeout;
    set_vec[`PIA_ST_CONV]   = src_rise.converter_result_ready;
    // comparator n lands at bit 4+n; trigger select 1 = rising, 0 = falling
    for (int n = 0; n < 4; n++) begin
      set_vec[`PIA_ST_CMP_LO + n] = trig_q[n] ? src_rise.comparator_hit[n]
                                              : src_fall.comparator_hit[n];
    end
  end

  assign clr_vec = (wr_fire && wr_sel == PIA_SEL_STATUS) ? wr_bits : 16'h0000;
  assign live    = status_q & ~mask_q;

  always_comb begin
    // a set in the same cycle as its clear survives
    status_d = ((status_q & ~clr_vec) | set_vec) & `PIA_ST_USED;
    mask_d   = mask_q;
    trig_d   = trig_q;
    if (wr_fire && wr_sel == PIA_SEL_MASK) begin
      mask_d = ((mask_q & ~{{8{w_strb_q[1]}}, {8{w_strb_q[0]}}}) | wr_bits) & `PIA_ST_USED;
    end
    if (wr_fire && wr_sel == PIA_SEL_TRIG && w_strb_q[0]) begin
      trig_d = w_data_q[3:0];
    end
    summary_d = 16'h0000;
    summary_d[`PIA_SUM_POWER]   = grp_level[`PIA_SUM_POWER];
    summary_d[`PIA_SUM_THERMAL] = grp_level[`PIA_SUM_THERMAL] | live[`PIA_ST_THERM];
    summary_d[`PIA_SUM_GPIO]    = grp_level[`PIA_SUM_GPIO];
    summary_d[`PIA_SUM_ONKEY]   = grp_level[`PIA_SUM_ONKEY] | live[`PIA_ST_ONKEY];
    summary_d[`PIA_SUM_WDOG]    = grp_level[`PIA_SUM_WDOG] | live[`PIA_ST_WDOG];
    summary_d[`PIA_SUM_CONV]    = grp_level[`PIA_SUM_CONV] | (|live[`PIA_ST_CONV:`PIA_ST_CMP_LO]);
    summary_d[`PIA_SUM_PPATH]   = grp_level[`PIA_SUM_PPATH] | live[`PIA_ST_LOWSUP];
    summary_d[`PIA_SUM_CLOCK]   = grp_level[`PIA_SUM_CLOCK] | live[`PIA_ST_TICK]
                                  | live[`PIA_ST_ALARM];
    summary_d[`PIA_SUM_OTP]     = grp_level[`PIA_SUM_OTP];
    summary_d[`PIA_SUM_CURRENT] = grp_level[`PIA_SUM_CURRENT];
    summary_d[`PIA_SUM_UNDERV]  = grp_level[`PIA_SUM_UNDERV];
    summary_d = summary_d & `PIA_SUM_USED;
    irq_d     = |summary_d;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      status_q  <= `PIA_RST_STATUS;
      mask_q    <= `PIA_RST_MASK;
      trig_q    <= `PIA_RST_TRIG;
      summary_q <= `PIA_RST_SUMMARY;
      irq_q     <= 1'b0;
    end else begin
      status_q  <= status_d;
      mask_q    <= mask_d;
      trig_q    <= trig_d;
      summary_q <= summary_d;
      irq_q     <= irq_d;
    end
  end

  // ---------------- read channel ----------------
  logic        arready_q;
  logic        arready_d;
  logic        rvalid_q;
  logic        rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0]  rresp_q;
  logic [1:0]  rresp_d;
  pia_sel_e    rd_sel;

  assign rd_sel = decode(s_axi_araddr);

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = `PIA_RESP_OKAY;
      if (rd_sel == PIA_SEL_SUMMARY) begin
        rdata_d = {16'h0000, summary_q};
      end else if (rd_sel == PIA_SEL_STATUS) begin
        rdata_d = {16'h0000, status_q};
      end else if (rd_sel == PIA_SEL_MASK) begin
        rdata_d = {16'h0000, mask_q};
      end else if (rd_sel == PIA_SEL_TRIG) begin
        rdata_d = {28'h0000000, trig_q};
      end else begin
        rdata_d = 32'h0000_0000;
        rresp_d = `PIA_RESP_DECERR;
      end
    end
    // one read in flight; next address waits for the data beat to drain
    arready_d = !rvalid_d;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `PIA_RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign irq           = irq_q;
endmodule

// File: tb/pia_top_properties.sv
`timescale 1ns/10ps
`include "pia_regs.svh"
module pia_top_chk (
  input wire logic              clk_sys,
  input wire logic              rstn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [31:0]       s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire pia_pkg::pia_src_s event_src,
  input wire pia_pkg::pia_word_t group_pending_in,
  input wire logic              irq
);
  import pia_pkg::*;
  localparam logic [31:0] A_SUM = {14'h0, `PIA_IDX_SUMMARY, 2'h0};
  logic mapped;
  assign mapped = s_axi_araddr inside {A_SUM, A_SUM + 32'h4, {14'h0, `PIA_IDX_MASK, 2'h0},
                                       {14'h0, `PIA_IDX_TRIG, 2'h0}};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid; endsequence
  sequence s_sup_rise; !event_src.low_supply_threshold ##1 event_src.low_supply_threshold [*5]; endsequence
  sequence s_key_fall; event_src.onkey_pin ##1 !event_src.onkey_pin [*5]; endsequence
  sequence s_pend; ($stable(group_pending_in) && |(group_pending_in & `PIA_SUM_USED)) [*6]; endsequence
  AST_SUM_UNUSED: assert property (
    s_rd_take and s_axi_araddr == A_SUM |=> (s_axi_rdata & ~{16'h0, `PIA_SUM_USED}) == 32'h0)
    else $error("summary unused bits not zero");
  AST_UNMAPPED: assert property (s_rd_take and !mapped |=> s_axi_rresp == `PIA_RESP_DECERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_PEND_IRQ: assert property (s_pend |-> irq)
    else $error("pending group without irq");
  AST_SUP_IRQ: assert property (s_sup_rise |-> irq)
    else $error("low supply rise without irq");
  AST_KEY_IRQ: assert property (s_key_fall |-> irq)
    else $error("onkey fall without irq");
  AST_RD_LAT: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped");
  // write is performed one edge after the handshake, so bvalid is seen two edges on
  AST_WR_RESP: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
endmodule
bind pia_top pia_top_chk i_chk (.clk_sys, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .event_src, .group_pending_in, .irq);

// File: tb/pia_host.sv
`timescale 1ns/10ps
module pia_host (
  input  wire logic  clk_sys,
  output logic [31:0] s_axi_awaddr,
  output logic        s_axi_awvalid,
  input  wire logic   s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0]  s_axi_wstrb,
  output logic        s_axi_wvalid,
  input  wire logic   s_axi_wready,
  input  wire logic   s_axi_bvalid,
  output logic        s_axi_bready,
  output logic [31:0] s_axi_araddr,
  output logic        s_axi_arvalid,
  input  wire logic   s_axi_arready,
  input  wire logic   s_axi_rvalid,
  output logic        s_axi_rready
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
  end
  // lag delays the ready so the slave must hold its answer
  task automatic wr(input logic [31:0] a, input logic [15:0] d, input int lag = 0);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_wstrb <= 4'h3;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    fork
      begin do @(posedge clk_sys); while (s_axi_awready !== 1'b1); s_axi_awvalid <= 1'b0; end
      begin do @(posedge clk_sys); while (s_axi_wready !== 1'b1); s_axi_wvalid <= 1'b0; end
    join
    repeat (lag) @(posedge clk_sys);
    s_axi_bready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input int lag = 0);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    repeat (lag) @(posedge clk_sys);
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
endmodule

// File: tb/pia_top_tb.sv
`timescale 1ns/10ps
`include "pia_regs.svh"
module pia_top_tb;
  import pia_pkg::*;
  localparam logic [31:0] A_SUM = {14'h0, `PIA_IDX_SUMMARY, 2'h0};
  localparam logic [31:0] A_ST  = {14'h0, `PIA_IDX_STATUS, 2'h0};
  localparam logic [31:0] A_MSK = {14'h0, `PIA_IDX_MASK, 2'h0};
  localparam logic [31:0] A_TRG = {14'h0, `PIA_IDX_TRIG, 2'h0};
  logic        clk_sys, rstn, irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  pia_src_s    event_src, s;
  pia_word_t   group_pending_in, r;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [1:0]  b_q[$];
  int          error_cnt, n_tests, seed, i;
  pia_top i_pia_top (.clk_sys, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .event_src, .group_pending_in, .irq);
  pia_host i_pia_host (.clk_sys, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic wt(input int n); repeat (n) @(posedge clk_sys); endtask
  // random ready delay makes the slave hold its answers
  function automatic int pick_lag();
    return $unsigned($random(seed)) % 4;
  endfunction
  task automatic chk(input logic [31:0] a, input logic [15:0] v, input logic [1:0] rs = `PIA_RESP_OKAY);
    exp_q.push_back({rs, 16'h0, v});
    i_pia_host.rd(a, pick_lag());
  endtask
  task automatic put(input logic [31:0] a, input logic [15:0] d, input logic [1:0] rs = `PIA_RESP_OKAY);
    b_q.push_back(rs);
    i_pia_host.wr(a, d, pick_lag());
  endtask
  task automatic irq_is(input logic v);
    n_tests++;
    if (irq !== v) begin
      error_cnt++;
      $display("mismatch %0t irq %b", $time, irq);
    end
  endtask
  // wait covers two sync flops, edge stage and summary
  task automatic ev(input pia_src_s v); @(posedge clk_sys); event_src <= v; wt(6); endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_sys) if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
    e = exp_q.pop_front();
    n_tests++;
    if ({s_axi_rresp, s_axi_rdata} !== e) begin
      error_cnt++;
      $display("mismatch %0t read %h want %h", $time, {s_axi_rresp, s_axi_rdata}, e);
    end
  end
  always @(posedge clk_sys) if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
    n_tests++;
    if (s_axi_bresp !== b_q.pop_front()) begin
      error_cnt++;
      $display("mismatch %0t bresp %h", $time, s_axi_bresp);
    end
  end
  initial begin
    wt(20000);
    error_cnt++;
    $display("mismatch %0t timeout", $time);
    final_report;
  end
  initial begin
    rstn = 1'b0;
    event_src = '0;
    group_pending_in = '0;
    seed = 91237;
    wt(8);
    rstn <= 1'b1;
    wt(2);
    chk(A_SUM, 16'h0);
    chk(A_ST, 16'h0);
    chk(A_MSK, 16'h0);
    chk(A_TRG, 16'h000f);
    irq_is(1'b0);
    $display("test reset done");
    ev('1);
    chk(A_ST, 16'h99fe);
    chk(A_SUM, 16'h59a0);
    irq_is(1'b1);
    put(A_ST, 16'h0);
    chk(A_ST, 16'h99fe);
    put(A_SUM, 16'hffff);
    chk(A_SUM, 16'h59a0);
    put(A_ST, 16'hffff);
    chk(A_ST, 16'h0);
    chk(A_SUM, 16'h0);
    ev('0);
    chk(A_ST, 16'h1002);
    put(A_ST, 16'h1002);
    $display("test edges done");
    put(A_TRG, 16'h0);
    for (i = 0; i < 4; i++) begin
      s = '0;
      s.comparator_hit = 4'h1 << i;
      ev(s);
      chk(A_ST, 16'h0);
      ev('0);
      chk(A_ST, 16'h10 << i);
      put(A_ST, 16'hffff);
    end
    $display("test comparators done");
    r = 16'($random(seed));
    put(A_TRG, r);
    chk(A_TRG, {12'h0, r[3:0]});
    put(A_MSK, 16'h0002);
    s = '0;
    s.thermal_warning = 1'b1;
    ev(s);
    chk(A_ST, 16'h0002);
    chk(A_SUM, 16'h0);
    irq_is(1'b0);
    put(A_MSK, 16'h0);
    wt(3);
    irq_is(1'b1);
    chk(A_SUM, 16'h4000);
    put(A_ST, 16'hffff);
    $display("test mask done");
    for (i = 0; i < 16; i++) begin
      @(posedge clk_sys) group_pending_in <= 16'h1 << i;
      wt(6);
      chk(A_SUM, (16'h1 << i) & `PIA_SUM_USED);
      irq_is(((16'h1 << i) & `PIA_SUM_USED) != 16'h0);
    end
    @(posedge clk_sys) group_pending_in <= '0;
    $display("test groups done");
    chk(A_ST + 32'h4, 16'h0, `PIA_RESP_DECERR);
    chk(A_ST | 32'h1, 16'h0, `PIA_RESP_DECERR);
    put(A_MSK + 32'h8, 16'hffff, `PIA_RESP_DECERR);
    chk(A_MSK, 16'h0);
    $display("test map done");
    final_report;
  end
endmodule
